//--- design/rtc_alarm_map.vh
// register map, field positions and timing counts of the alarm and trim block
// assumes a 32-bit wishbone bus with byte addresses and a 32.768 khz pulse input
`ifndef RTC_ALARM_MAP_VH
`define RTC_ALARM_MAP_VH

`define ADR_ALARM_WINDOW 6'h00
`define ADR_ALARM_CFG 6'h04
`define ADR_TRIM 6'h08
`define ADR_IRQ_STATUS 6'h0c
`define ADR_IRQ_MASK 6'h10
`define ADR_TIME_STATE 6'h14

`define CFG_ENABLE 15
`define CFG_ENDLESS 14
`define CFG_MASK_HI 13
`define CFG_MASK_LO 10
`define CFG_PTR_HI 9
`define CFG_PTR_LO 8
`define CFG_RPT_HI 7
`define CFG_RPT_LO 0

`define TRIM_TIMER_ON 15
`define TRIM_SYNC 12
`define TRIM_HI 7
`define TRIM_LO 0

`define PAIR_MINSEC 2'h0
`define PAIR_WDHR 2'h1
`define PAIR_MTHDY 2'h2
`define PAIR_NONE 2'h3
`define IMPL_MINSEC 16'h7f7f
`define IMPL_WDHR 16'h073f
`define IMPL_MTHDY 16'h1f3f

`define TENS_MAX 3'h5
`define ONES_MAX 4'h9
`define MINSEC_BYTES 2
`define BYTE_BITS 8
`define PAD_BIT 7
`define DIGIT_TENS_HI 6
`define DIGIT_TENS_LO 4
`define DIGIT_ONES_HI 3
`define DIGIT_ONES_LO 0
`define RPT_ZERO 8'h00
`define RPT_FULL 8'hff

`define HALF_SEC_PULSES 17'sh04000
`define SYNC_WINDOW 17'sh00020
`define HALF_TICKS_PER_MIN 7'h77
`define TRIM_SHIFT 2

`define IRQ_ALARM 0
`define IRQ_MINUTE 1
`define IRQ_BITS 2

`define MASK_HALF 4'h0
`define MASK_SEC 4'h1
`define MASK_TENSEC 4'h2
`define MASK_MIN 4'h3
`define MASK_TENMIN 4'h4
`define MASK_HOUR 4'h5
`define MASK_DAY 4'h6
`define MASK_WEEK 4'h7
`define MASK_MONTH 4'h8
`define MASK_YEAR 4'h9

`endif

//--- design/alarm_match.v
// digit comparator: decides whether the selected alarm digits equal the clock
// assumes alarm and time pairs share the same bcd layout
`timescale 1ns/1ps
`default_nettype none
`include "rtc_alarm_map.vh"

module alarm_match (
	input wire [3:0] digit_mask,
	input wire full_second,
	input wire [15:0] alarm_min_sec,
	input wire [15:0] alarm_wd_hr,
	input wire [15:0] alarm_mth_day,
	input wire [15:0] time_min_sec,
	input wire [15:0] time_wd_hr,
	input wire [15:0] time_mth_day,
	output reg match
);
	wire sec_ones_eq;
	wire sec_eq;
	wire min_ones_eq;
	wire min_eq;
	wire hr_eq;
	wire wd_eq;
	wire day_eq;
	wire mth_eq;

	assign sec_ones_eq = alarm_min_sec[3:0] == time_min_sec[3:0];
	assign sec_eq = alarm_min_sec[6:0] == time_min_sec[6:0];
	assign min_ones_eq = alarm_min_sec[11:8] == time_min_sec[11:8];
	assign min_eq = alarm_min_sec[14:8] == time_min_sec[14:8];
	assign hr_eq = alarm_wd_hr[5:0] == time_wd_hr[5:0];
	assign wd_eq = alarm_wd_hr[10:8] == time_wd_hr[10:8];
	assign day_eq = alarm_mth_day[5:0] == time_mth_day[5:0];
	assign mth_eq = alarm_mth_day[12:8] == time_mth_day[12:8];

	// more mask steps add more digits, the month step comparing day in place of weekday; whole-second masks ignore half ticks
	always @* begin
		case (digit_mask)
		`MASK_HALF: match = 1'b1;
		`MASK_SEC: match = full_second;
		`MASK_TENSEC: match = full_second & sec_ones_eq;
		`MASK_MIN: match = full_second & sec_eq;
		`MASK_TENMIN: match = full_second & sec_eq & min_ones_eq;
		`MASK_HOUR: match = full_second & sec_eq & min_eq;
		`MASK_DAY: match = full_second & sec_eq & min_eq & hr_eq;
		`MASK_WEEK: match = full_second & sec_eq & min_eq & hr_eq & wd_eq;
		`MASK_MONTH: match = full_second & sec_eq & min_eq & hr_eq & day_eq;
		`MASK_YEAR: match = full_second & sec_eq & min_eq & hr_eq & day_eq & mth_eq;
		default: match = 1'b0;
		endcase
	end
endmodule // alarm_match

`default_nettype wire

//--- design/rtc_alarm_calibration.v
// alarm, repeat and crystal trim logic of a calendar clock, wishbone slave
// assumes rtc_pulse is a one-cycle strobe per 32.768 khz crystal period,
// synchronous to sys_clk, and cur_* digits come from the calendar counters
//
// Summary of operation
// - minutes alarm digits: tens in 14-12 up to 5, ones in 11-8 up to 9.
// - seconds alarm digits: tens in 6-4 up to 5, ones in 3-0 up to 9.
// - bits 15 and 7 of the minutes/seconds alarm always read zero.
// - signed trim byte times four pulses added to timer once per minute.
// - negative trim removes pulses each minute for a fast crystal.
// - config bit 15 enables the alarm; spans half second to one year.
// - four-bit mask at 13:10 picks which digits must match.
// - repeat count at 7:0; zero gives one alarm, ff gives 255 repeats.
// - each alarm decrements count; at zero, last alarm then enable clears.
// - endless bit 14 wraps count from zero to ff and keeps alarming.
// - every alarm event sets the alarm status bit; irq rises only if its mask bit is set.
// - alarm pulse output toggles on each alarm, synchronous to clock.
// - two-bit pointer picks alarm pair; high-byte access decrements to zero.
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_alarm_map.vh"

module rtc_alarm_calibration (
	input wire sys_clk,
	input wire rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire rtc_pulse,
	input wire [15:0] cur_min_sec,
	input wire [15:0] cur_wd_hr,
	input wire [15:0] cur_mth_day,
	output reg half_sec_tick,
	output reg seconds_pulse,
	output reg alarm_pulse,
	output reg irq
);
	// alarm value pairs, indexed by the value pointer
	reg [15:0] alarm_pair_reg [0:2];
	reg [15:0] alarm_pair_next [0:2];
	reg [15:0] alarm_config_repeat_reg;
	reg [15:0] alarm_config_repeat_next;
	reg [7:0] trim_reg;
	reg [7:0] trim_next;
	reg timer_on_reg;
	reg timer_on_next;
	reg [`IRQ_BITS-1:0] irq_status_reg;
	wire [`IRQ_BITS-1:0] irq_status_next;
	reg [`IRQ_BITS-1:0] irq_mask_reg;
	reg [`IRQ_BITS-1:0] irq_mask_next;
	reg signed [16:0] pulse_count_reg;
	reg signed [16:0] pulse_count_next;
	reg [6:0] half_count_reg;
	reg [6:0] half_count_next;
	reg half_phase_reg;
	reg half_phase_next;
	reg sync_reg;
	reg sync_next;
	reg [31:0] rd_data_next;
	reg [15:0] pair_wr;
	reg [15:0] pair_merge;
	reg [15:0] pair_rd;
	reg [15:0] impl_mask;
	reg alarm_event;
	reg minute_event;
	reg half_tick_now;

	wire bus_req;
	wire bus_fire;
	wire wr_fire;
	wire hi_touch;
	wire digit_match;
	wire [1:0] ptr;
	wire signed [16:0] trim_pulses;
	wire [15:0] pair_clamped;
	wire [`IRQ_BITS-1:0] irq_event;
	wire [`IRQ_BITS-1:0] status_clear;

	genvar d;
	genvar b;

	// ack one cycle after the request; the write lands on the acked edge
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign bus_fire = bus_req & wb_ack_o;
	assign wr_fire = bus_fire & wb_we_i;
	// reads count as upper-byte accesses too
	assign hi_touch = bus_fire & (wb_adr_i == `ADR_ALARM_WINDOW) & wb_sel_i[1];
	assign ptr = alarm_config_repeat_reg[`CFG_PTR_HI:`CFG_PTR_LO];
	// sign-extended trim times four
	assign trim_pulses = {{7{trim_reg[7]}}, trim_reg, 2'b00};

	alarm_match u_match (
		.digit_mask(alarm_config_repeat_reg[`CFG_MASK_HI:`CFG_MASK_LO]),
		.full_second(half_phase_reg),
		.alarm_min_sec(alarm_pair_reg[0]),
		.alarm_wd_hr(alarm_pair_reg[1]),
		.alarm_mth_day(alarm_pair_reg[2]),
		.time_min_sec(cur_min_sec),
		.time_wd_hr(cur_wd_hr),
		.time_mth_day(cur_mth_day),
		.match(digit_match)
	);

	// implemented-bit mask of the pair the pointer selects
	always @* begin
		case (ptr)
		`PAIR_MINSEC: impl_mask = `IMPL_MINSEC;
		`PAIR_WDHR: impl_mask = `IMPL_WDHR;
		`PAIR_MTHDY: impl_mask = `IMPL_MTHDY;
		default: impl_mask = 16'h0000;
		endcase
	end

	always @* begin
		if (ptr == `PAIR_NONE) begin
			pair_rd = 16'h0000;
		end else begin
			pair_rd = alarm_pair_reg[ptr] & impl_mask;
		end
	end

	// merge the written bytes into the selected pair
	always @* begin
		pair_merge = pair_rd;
		if (wb_sel_i[0]) begin
			pair_merge[7:0] = wb_dat_i[7:0];
		end
		if (wb_sel_i[1]) begin
			pair_merge[15:8] = wb_dat_i[15:8];
		end
		pair_merge = pair_merge & impl_mask;
	end

	// one bcd clamp per byte: byte 1 minutes, byte 0 seconds
	// non-bcd digits could never match the calendar, so they pin to the top value
	generate
		for (d = 0; d < `MINSEC_BYTES; d = d + 1) begin : bcd_byte
			wire [2:0] tens;
			wire [3:0] ones;
			assign tens = pair_merge[d*`BYTE_BITS+`DIGIT_TENS_HI:d*`BYTE_BITS+`DIGIT_TENS_LO];
			assign ones = pair_merge[d*`BYTE_BITS+`DIGIT_ONES_HI:d*`BYTE_BITS+`DIGIT_ONES_LO];
			assign pair_clamped[d*`BYTE_BITS+`PAD_BIT] = 1'b0;
			assign pair_clamped[d*`BYTE_BITS+`DIGIT_TENS_HI:d*`BYTE_BITS+`DIGIT_TENS_LO] =
				(tens > `TENS_MAX) ? `TENS_MAX : tens;
			assign pair_clamped[d*`BYTE_BITS+`DIGIT_ONES_HI:d*`BYTE_BITS+`DIGIT_ONES_LO] =
				(ones > `ONES_MAX) ? `ONES_MAX : ones;
		end
	endgenerate

	// only the minutes/seconds pair carries these digit limits
	always @* begin
		if (ptr == `PAIR_MINSEC) begin
			pair_wr = pair_clamped;
		end else begin
			pair_wr = pair_merge;
		end
	end

	// prescaler: half-second ticks from crystal pulses, trim applied at the minute
	always @* begin
		pulse_count_next = pulse_count_reg;
		half_count_next = half_count_reg;
		half_phase_next = half_phase_reg;
		half_tick_now = 1'b0;
		minute_event = 1'b0;
		if (timer_on_reg && rtc_pulse) begin
			if (pulse_count_reg >= `HALF_SEC_PULSES - 17'sd1) begin
				half_tick_now = 1'b1;
				half_phase_next = ~half_phase_reg;
				if (half_count_reg == `HALF_TICKS_PER_MIN) begin
					// a head start adds pulses; a negative start removes them
					half_count_next = 7'h00;
					minute_event = 1'b1;
					pulse_count_next = trim_pulses;
				end else begin
					half_count_next = half_count_reg + 7'h01;
					pulse_count_next = 17'sd0;
				end
			end else begin
				pulse_count_next = pulse_count_reg + 17'sd1;
			end
		end
		// warns software that a rollover is close
		sync_next = timer_on_reg &&
			(pulse_count_next >= `HALF_SEC_PULSES - `SYNC_WINDOW);
	end

	// alarm decision on the tick; repeat bookkeeping is done in regs_next
	always @* begin
		alarm_event = half_tick_now & alarm_config_repeat_reg[`CFG_ENABLE] &
			digit_match;
	end

	// status bits: write one to clear, but an event in the same cycle wins
	assign status_clear = (wr_fire && wb_adr_i == `ADR_IRQ_STATUS && wb_sel_i[0]) ?
		wb_dat_i[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};
	assign irq_event[`IRQ_ALARM] = alarm_event;
	assign irq_event[`IRQ_MINUTE] = minute_event;

	generate
		for (b = 0; b < `IRQ_BITS; b = b + 1) begin : status_bit
			assign irq_status_next[b] = irq_event[b] |
				(irq_status_reg[b] & ~status_clear[b]);
		end
	endgenerate

	// register writes, then hardware updates on top so events are never lost
	always @* begin : regs_next
		integer i;
		for (i = 0; i < 3; i = i + 1) begin
			alarm_pair_next[i] = alarm_pair_reg[i];
		end
		alarm_config_repeat_next = alarm_config_repeat_reg;
		trim_next = trim_reg;
		timer_on_next = timer_on_reg;
		irq_mask_next = irq_mask_reg;
		if (wr_fire) begin
			case (wb_adr_i)
			`ADR_ALARM_WINDOW: begin
				if (ptr != `PAIR_NONE) begin
					alarm_pair_next[ptr] = pair_wr;
				end
			end
			`ADR_ALARM_CFG: begin
				if (wb_sel_i[0]) begin
					alarm_config_repeat_next[7:0] = wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					alarm_config_repeat_next[15:8] = wb_dat_i[15:8];
				end
			end
			`ADR_TRIM: begin
				if (wb_sel_i[0]) begin
					trim_next = wb_dat_i[`TRIM_HI:`TRIM_LO];
				end
				if (wb_sel_i[1]) begin
					timer_on_next = wb_dat_i[`TRIM_TIMER_ON];
				end
			end
			`ADR_IRQ_MASK: begin
				if (wb_sel_i[0]) begin
					irq_mask_next = wb_dat_i[`IRQ_BITS-1:0];
				end
			end
			default: begin
			end
			endcase
		end
		// pointer steps down on each upper-byte access and parks at zero
		if (hi_touch && ptr != `PAIR_MINSEC) begin
			alarm_config_repeat_next[`CFG_PTR_HI:`CFG_PTR_LO] = ptr - 2'h1;
		end
		if (alarm_event) begin
			if (alarm_config_repeat_reg[`CFG_RPT_HI:`CFG_RPT_LO] != `RPT_ZERO) begin
				alarm_config_repeat_next[`CFG_RPT_HI:`CFG_RPT_LO] =
					alarm_config_repeat_reg[`CFG_RPT_HI:`CFG_RPT_LO] - 8'h01;
			end else if (alarm_config_repeat_reg[`CFG_ENDLESS]) begin
				alarm_config_repeat_next[`CFG_RPT_HI:`CFG_RPT_LO] = `RPT_FULL;
			end else begin
				alarm_config_repeat_next[`CFG_ENABLE] = 1'b0;
			end
		end
	end

	// read mux; unmapped addresses read zero
	always @* begin
		rd_data_next = 32'h0000_0000;
		case (wb_adr_i)
		`ADR_ALARM_WINDOW: rd_data_next[15:0] = pair_rd;
		`ADR_ALARM_CFG: rd_data_next[15:0] = alarm_config_repeat_reg;
		`ADR_TRIM: begin
			rd_data_next[`TRIM_HI:`TRIM_LO] = trim_reg;
			rd_data_next[`TRIM_SYNC] = sync_reg;
			rd_data_next[`TRIM_TIMER_ON] = timer_on_reg;
		end
		`ADR_IRQ_STATUS: rd_data_next[`IRQ_BITS-1:0] = irq_status_reg;
		`ADR_IRQ_MASK: rd_data_next[`IRQ_BITS-1:0] = irq_mask_reg;
		`ADR_TIME_STATE: rd_data_next[16:0] = pulse_count_reg;
		default: rd_data_next = 32'h0000_0000;
		endcase
	end

	always @(posedge sys_clk) begin : seq
		integer i;
		if (rst) begin
			for (i = 0; i < 3; i = i + 1) begin
				alarm_pair_reg[i] <= 16'h0000;
			end
			alarm_config_repeat_reg <= 16'h0000;
			trim_reg <= 8'h00;
			timer_on_reg <= 1'b0;
			irq_status_reg <= {`IRQ_BITS{1'b0}};
			irq_mask_reg <= {`IRQ_BITS{1'b0}};
			pulse_count_reg <= 17'sd0;
			half_count_reg <= 7'h00;
			half_phase_reg <= 1'b0;
			sync_reg <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			half_sec_tick <= 1'b0;
			seconds_pulse <= 1'b0;
			alarm_pulse <= 1'b0;
			irq <= 1'b0;
		end else begin
			for (i = 0; i < 3; i = i + 1) begin
				alarm_pair_reg[i] <= alarm_pair_next[i];
			end
			alarm_config_repeat_reg <= alarm_config_repeat_next;
			trim_reg <= trim_next;
			timer_on_reg <= timer_on_next;
			irq_status_reg <= irq_status_next;
			irq_mask_reg <= irq_mask_next;
			pulse_count_reg <= pulse_count_next;
			half_count_reg <= half_count_next;
			half_phase_reg <= half_phase_next;
			sync_reg <= sync_next;
			// ack drops the cycle after it is given
			wb_ack_o <= bus_req & ~wb_ack_o;
			// read data taken when the request is first seen, before the pointer steps
			if (bus_req && !wb_ack_o) begin
				wb_dat_o <= rd_data_next;
			end
			half_sec_tick <= half_tick_now;
			seconds_pulse <= half_phase_next;
			if (alarm_event) begin
				alarm_pulse <= ~alarm_pulse;
			end
			irq <= |(irq_status_next & irq_mask_next);
		end
	end
endmodule // rtc_alarm_calibration

`default_nettype wire

//--- bench/rtc_alarm_assertions.sv
// port checker for the alarm and trim block
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic half_sec_tick,
	input wire logic alarm_pulse,
	input wire logic irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// past(rst) guards keep the reset clear from looking like an event
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	upper_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i != 6'h14
		|-> wb_dat_o[31:16] == 16'h0000) else $error("upper read half not zero");
	window_unused_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 6'h00
		|-> !wb_dat_o[15] && !wb_dat_o[7]) else $error("unused window bit reads one");
	pulse_on_tick_a: assert property (!$past(rst) && $changed(alarm_pulse)
		|-> half_sec_tick) else $error("alarm pulse moved off a tick");
	irq_rise_a: assert property ($rose(irq)
		|-> half_sec_tick || $past(wb_ack_o && wb_we_i)) else $error("irq rose without cause");
	irq_fall_a: assert property (!$past(rst) && $fell(irq)
		|-> $past(wb_ack_o && wb_we_i)) else $error("irq fell without a write");
	cover property ($changed(alarm_pulse));
	cover property ($rose(irq));
	cover property (wb_ack_o && wb_adr_i == 6'h00);
endmodule // rtc_alarm_checker
bind rtc_alarm_calibration rtc_alarm_checker chk (.sys_clk(sys_clk), .rst(rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .half_sec_tick(half_sec_tick),
	.alarm_pulse(alarm_pulse), .irq(irq));
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the alarm and trim block
// assumes rtc_pulse may strobe every cycle, so half a second is 16384 cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic rtc_pulse = 1'b0;
	logic [15:0] cur_ms = 16'h0000;
	logic [15:0] cur_wh = 16'h0000;
	logic [15:0] cur_md = 16'h0000;
	logic [31:0] q;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, half_sec_tick, seconds_pulse, alarm_pulse, irq;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;
	int gap = 0;
	int last_gap = 0;

	rtc_alarm_calibration DUT (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .rtc_pulse(rtc_pulse), .cur_min_sec(cur_ms), .cur_wd_hr(cur_wh),
		.cur_mth_day(cur_md), .half_sec_tick(half_sec_tick), .seconds_pulse(seconds_pulse),
		.alarm_pulse(alarm_pulse), .irq(irq));

	always #50 sys_clk = ~sys_clk;

	// gap counts edges between ticks, checked once two ticks have passed
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		gap <= (half_sec_tick === 1'b1) ? 1 : gap + 1;
		if (half_sec_tick === 1'b1) last_gap <= gap;
		if (cycles == 80000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one classic cycle; read data taken at the ack edge
	task automatic bus(input logic [5:0] a, input logic w, input logic [3:0] s,
		input logic [31:0] d);
		int n = 0;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) mismatches++;
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wait_tick;
		int n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (half_sec_tick !== 1'b1 && n < 20000);
		if (half_sec_tick !== 1'b1) mismatches++;
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		rtc_pulse <= 1'b1;
		bus(6'h04, 0, 4'h3, 0);
		chk(q, 32'h0);
		bus(6'h0c, 0, 4'h3, 0);
		chk(q, 32'h0);
		// clamp: low byte alone first, high lane untouched
		bus(6'h00, 1, 4'h1, 32'h00ff);
		bus(6'h00, 0, 4'h1, 0);
		chk(q, 32'h0059);
		bus(6'h00, 1, 4'h3, 32'h7fff);
		bus(6'h00, 0, 4'h3, 0);
		chk(q, 32'h5959);
		bus(6'h04, 1, 4'h3, 32'h0200);
		bus(6'h00, 1, 4'h3, 32'h1234);
		bus(6'h04, 0, 4'h3, 0);
		chk(q, 32'h0100);
		bus(6'h00, 0, 4'h3, 0);
		chk(q, 32'h0000);
		bus(6'h00, 0, 4'h3, 0);
		chk(q, 32'h5959);
		bus(6'h04, 0, 4'h3, 0);
		chk(q, 32'h0000);
		bus(6'h04, 1, 4'h3, 32'h0200);
		bus(6'h00, 0, 4'h1, 0);
		chk(q, 32'h1234);
		bus(6'h04, 0, 4'h3, 0);
		chk(q, 32'h0200);
		bus(6'h20, 1, 4'h3, 32'hffff);
		bus(6'h20, 0, 4'h3, 0);
		chk(q, 32'h0);
		bus(6'h10, 1, 4'h1, 32'h1);
		// crystal 16 pulses a minute fast: trim -4, written in the same access that turns the timer on
		bus(6'h08, 1, 4'h3, 32'h80fc);
		bus(6'h08, 0, 4'h3, 0);
		chk(q, 32'h80fc);
		// mask 0 fires every tick; one repeat means two alarms
		bus(6'h04, 1, 4'h3, 32'h8001);
		wait_tick;
		chk({31'h0, alarm_pulse}, 32'h1);
		chk({31'h0, seconds_pulse}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		bus(6'h04, 0, 4'h3, 0);
		chk(q, 32'h8000);
		wait_tick;
		chk({31'h0, alarm_pulse}, 32'h0);
		chk({31'h0, seconds_pulse}, 32'h0);
		bus(6'h04, 0, 4'h3, 0);
		chk(q, 32'h0000);
		chk(last_gap, 32'd16384);
		bus(6'h0c, 1, 4'h1, 32'h1);
		bus(6'h0c, 0, 4'h3, 0);
		chk(q, 32'h0);
		chk({31'h0, irq}, 32'h0);
		bus(6'h10, 1, 4'h1, 32'h0);
		bus(6'h04, 1, 4'h3, 32'hc000);
		wait_tick;
		chk({31'h0, alarm_pulse}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		bus(6'h04, 0, 4'h3, 0);
		chk(q, 32'hc0ff);
		bus(6'h10, 1, 4'h1, 32'h1);
		bus(6'h0c, 0, 4'h3, 0);
		chk(q, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wrap_up();
	end
endmodule // tb
`default_nettype wire
